//--- design/memref_pkg.sv
// shared types and constants for the byte-mode memory-reference executor
package memref_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // widths and fixed values
  localparam int unsigned WORD_W      = 16;           // data word width
  localparam int unsigned WADDR_W     = 15;           // word address width
  localparam int unsigned DISP_W      = 10;           // signed/unsigned displacement field
  localparam int unsigned COUNT_W     = 8;            // suspend operand width
  localparam logic [15:0] A_RESET     = 16'h0000;     // accumulator after reset
  localparam logic [15:0] X_RESET     = 16'h0000;     // index after reset
  localparam logic [14:0] P_RESET     = 15'h0000;     // program counter after reset
  localparam logic [1:0]  BE_WORD     = 2'h3;         // both byte lanes
  localparam logic [1:0]  BE_UPPER    = 2'h2;         // upper lane, pointer bit 0 clear
  localparam logic [1:0]  BE_LOWER    = 2'h1;         // lower lane, pointer bit 0 set
  localparam int unsigned LANE_BIT    = 0;            // byte pointer bit selecting the lane

  //////////////////////////////////////////////////////////////////////////////
  // instruction codes
  typedef enum logic [4:0] {
    set_byte_mode_op       = 5'h00,
    suspend_byte_for_count = 5'h01,
    word_mode_set_op       = 5'h02,
    force_word_op_a        = 5'h03,
    force_word_op_b        = 5'h04,
    increment_skip_zero    = 5'h05,
    multiply_op            = 5'h06,
    divide_op              = 5'h07,
    normalize_op           = 5'h08,
    jump_op                = 5'h09,
    jump_and_save          = 5'h0A,
    xor_acc_byte           = 5'h0B,
    load_acc_word          = 5'h0C,
    load_acc_byte          = 5'h0D,
    load_index_word        = 5'h0E,
    load_index_byte        = 5'h0F,
    store_acc_word         = 5'h10,
    store_acc_byte         = 5'h11,
    store_index_word       = 5'h12,
    store_index_byte       = 5'h13,
    exchange_mem_acc       = 5'h14,
    exchange_mem_acc_byte  = 5'h15,
    compare_skip_word      = 5'h16,
    compare_skip_byte      = 5'h17,
    scan_words             = 5'h18,
    scan_bytes             = 5'h19
  } op_e;

  // addressing forms
  typedef enum logic [1:0] {
    am_direct   = 2'h0,
    am_indirect = 2'h1,
    am_indexed  = 2'h2,
    am_postidx  = 2'h3
  } addr_mode_e;

  // decoded instruction handed in by the fetch logic
  typedef struct packed {
    op_e                op;          // operation
    addr_mode_e         mode;        // addressing form
    logic               rel;         // p-relative instead of base page
    logic [DISP_W-1:0]  disp;        // displacement / base value
    logic [COUNT_W-1:0] count;       // suspend operand
    logic               intr;        // executed as an interrupt instruction
  } instr_s;

  // memory request, one outstanding at a time
  typedef struct packed {
    logic               valid;       // request pending until ack
    logic               we;          // write
    logic [WADDR_W-1:0] addr;        // word address
    logic [WORD_W-1:0]  wdata;       // write data, byte copied to both lanes
    logic [1:0]         be;          // byte lanes written
  } mem_req_s;

endpackage : memref_pkg

//--- design/byte_addr_unit.sv
// effective address former for word and byte memory references
module byte_addr_unit
  import memref_pkg::*;
(
  // decoded addressing
  input  wire addr_mode_e         mode,
  input  wire logic               rel,
  input  wire logic [DISP_W-1:0]  disp,
  input  wire logic               is_byte,
  // machine state
  input  wire logic [WORD_W-1:0]  x,
  input  wire logic [WADDR_W-1:0] p,
  input  wire logic [WORD_W-1:0]  ptr,
  // results
  output logic [WADDR_W-1:0]      ptr_addr,
  output logic [WADDR_W-1:0]      ea_word,
  output logic                    ea_lane
);

  logic [WORD_W-1:0] base8;    // base page value, 0 to 255
  logic [WORD_W-1:0] pwide;    // p zero-extended
  logic [WORD_W-1:0] dsext;    // displacement sign-extended
  logic [WORD_W-1:0] bea;      // byte address
  logic [WORD_W-1:0] wea;      // word address, 16-bit scratch

  assign base8 = {8'h00, disp[7:0]};
  assign pwide = {1'b0, p};
  assign dsext = {{(WORD_W-DISP_W){disp[DISP_W-1]}}, disp};

  // pointer word: scratchpad, or p plus -512..+511 words
  always_comb begin
    if (rel && mode == am_indirect) begin
      ptr_addr = WADDR_W'(pwide + dsext); // [RL8]
    end else begin
      ptr_addr = WADDR_W'(base8); // [RL8] [RL10]
    end
  end

  // byte addresses use all 16 pointer bits, one level only
  always_comb begin
    unique case (mode)
      am_direct:   bea = rel ? {p, 1'b0} + {7'h00, disp[8:0]} : base8; // [RL7]
      am_indirect: bea = ptr;          // [RL4]
      am_indexed:  bea = x + base8;    // [RL9]
      am_postidx:  bea = ptr + x;      // [RL10]
    endcase
  end

  // word forms mirror the byte ones at word granularity
  always_comb begin
    unique case (mode)
      am_direct:   wea = rel ? WORD_W'(pwide + {7'h00, disp[8:0]}) : base8;
      am_indirect: wea = {1'b0, ptr[WADDR_W-1:0]};
      am_indexed:  wea = x + base8;
      am_postidx:  wea = {1'b0, ptr[WADDR_W-1:0]} + x;
    endcase
  end

  // byte refs: upper 15 bits give the word, bit 0 the lane; word refs take the low 15 bits, lane 0
  always_comb begin
    if (is_byte) begin
      ea_word = bea[WORD_W-1:1]; // [RL3]
      ea_lane = bea[LANE_BIT];   // [RL3]
    end else begin
      ea_word = wea[WADDR_W-1:0];
      ea_lane = 1'b0;
    end
  end

endmodule : byte_addr_unit

//--- design/byte_mode_memref_exec.sv
// memory-reference executor with byte/word mode, byte addressing and scans

// Operation
// RL1: byte-mode op sets, forcing ops clear mode
// RL2: suspend inhibits byte mode for count
// RL3: pointer upper 15 bits word, bit0 lane
// RL4: byte indirect follows exactly one pointer
// RL5: byte operands use register low byte
// RL6: listed non-byte instructions always use words
// RL7: direct reaches base 256 bytes, 512 forward
// RL8: pointer from scratchpad or p-relative window
// RL9: indexed adds x to base 0..255
// RL10: postindexed adds x to scratchpad pointer
// RL11: byte xor into a low byte only
// RL12: word load, store and exchange
// RL13: byte load zero-fills, byte store low byte
// RL14: byte exchange stores and loads simultaneously
// RL15: word compare skips one high, two equal
// RL16: byte compare same skip, zero-extended byte
// RL17: increment, skip on zero, set overflow
// RL18: interrupt increment zero sends echo notice
// RL19: jump loads p with effective address
// RL20: jump-and-save stores return, disables interrupts (code pulses int_disable only when executed as an interrupt instruction)
// RL21: word scan downward, skip when exhausted
// RL22: byte scan downward, skip when exhausted
// RL23: scans yield to interrupts, resume later
// RL24: byte writes touch only their lane
module byte_mode_memref_exec
  import memref_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // instruction handoff
  input  wire logic               instr_valid,
  input  wire instr_s             instr,
  output logic                    instr_ready,
  output logic                    done,
  // interrupt system
  input  wire logic               irq_pending,
  output logic                    echo,
  output logic                    int_disable,
  output logic                    scan_yield,
  // main memory
  output mem_req_s                mem_req,
  input  wire logic               mem_ack,
  input  wire logic [WORD_W-1:0]  mem_rdata,
  // machine state
  output logic [WORD_W-1:0]       acc,
  output logic [WORD_W-1:0]       index,
  output logic [WADDR_W-1:0]      pc,
  output logic                    arith_excess_flag,
  output logic                    byte_mode
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [5:0] {
    st_idle   = 6'b000001,
    st_decode = 6'b000010,
    st_ptr    = 6'b000100,
    st_read   = 6'b001000,
    st_write  = 6'b010000,
    st_scan   = 6'b100000
  } state_e;

  state_e             state, next_state;        // sequencer
  instr_s             ir;                       // latched instruction
  logic [WORD_W-1:0]  ptr, next_ptr;            // fetched pointer
  logic               ptr_ok, next_ptr_ok;      // pointer already fetched
  logic [1:0]         skip, next_skip;          // pending skip words
  logic [COUNT_W-1:0] sus_cnt, next_sus_cnt;    // suspend countdown
  logic               next_mode;                // next byte mode
  mem_req_s           next_req;                 // next memory request
  logic [WORD_W-1:0]  next_acc, next_index;     // next registers
  logic [WADDR_W-1:0] next_pc;
  logic               next_ov, next_done, next_echo, next_intdis, next_yield;

  logic               byte_op, byte_eff, need_ptr, is_scan;
  logic [WADDR_W-1:0] ptr_addr, ea_word;
  logic               ea_lane;
  logic [7:0]         rbyte;                    // selected read byte
  logic [WORD_W-1:0]  operand;                  // word or zero-extended byte
  logic [WORD_W-1:0]  incr;                     // incremented word
  logic [7:0]         src_byte;                 // register low byte to store

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers
  assign byte_op  = ir.op inside {xor_acc_byte, load_acc_byte, load_index_byte, store_acc_byte,
                                  store_index_byte, exchange_mem_acc_byte, compare_skip_byte,
                                  scan_bytes};
  // increment, multiply, divide, normalize, jumps never enter the byte set
  assign byte_eff = byte_op && byte_mode && (sus_cnt == '0); // [RL2] [RL6]
  assign is_scan  = ir.op inside {scan_words, scan_bytes};
  assign need_ptr = is_scan || ir.mode inside {am_indirect, am_postidx};

  // scans always run pointer plus x
  byte_addr_unit u_addr (
    .mode     (is_scan ? am_postidx : ir.mode),
    .rel      (ir.rel),
    .disp     (ir.disp),
    .is_byte  (byte_eff),
    .x        (index),
    .p        (pc),
    .ptr      (ptr),
    .ptr_addr (ptr_addr),
    .ea_word  (ea_word),
    .ea_lane  (ea_lane)
  );

  // lane 0 is the upper byte of the word
  assign rbyte    = ea_lane ? mem_rdata[7:0] : mem_rdata[15:8]; // [RL3]
  assign operand  = byte_eff ? {8'h00, rbyte} : mem_rdata;      // [RL16]
  assign incr     = mem_rdata + 16'h0001;
  assign src_byte = ir.op inside {store_index_byte, store_index_word} ? index[7:0] : acc[7:0]; // [RL5]

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_state   = state;
    next_ptr     = ptr;
    next_ptr_ok  = ptr_ok;
    next_skip    = skip;
    next_sus_cnt = sus_cnt;
    next_mode    = byte_mode;
    next_req     = mem_req;
    next_acc     = acc;
    next_index   = index;
    next_pc      = pc;
    next_ov      = arith_excess_flag;
    next_done    = 1'b0;
    next_echo    = 1'b0;
    next_intdis  = 1'b0;
    next_yield   = 1'b0;
    if (mem_req.valid && mem_ack) begin
      next_req.valid = 1'b0;                    // one beat per request
    end
    unique case (state)
      st_idle: begin
        if (instr_valid) begin
          next_state  = st_decode;
          next_ptr_ok = 1'b0;
          next_skip   = 2'h0;
        end
      end
      st_decode: begin
        if (ir.op inside {set_byte_mode_op, suspend_byte_for_count, word_mode_set_op,
                          force_word_op_a, force_word_op_b, multiply_op, divide_op, normalize_op}) begin
          next_state = st_idle;                 // mode, multiply, divide and normalize ops finish here
          next_done  = 1'b1;
          if (!ir.intr) begin
            next_pc = pc + 15'h0001;
          end
          unique case (ir.op)
            set_byte_mode_op:       next_mode = 1'b1; // [RL1]
            word_mode_set_op,
            force_word_op_a,
            force_word_op_b:        next_mode = 1'b0; // [RL1] [RL2]
            default:                next_mode = byte_mode;
          endcase
        end else if (need_ptr && !ptr_ok) begin
          next_state = st_ptr;                  // single pointer level
          next_req   = '{valid: 1'b1, we: 1'b0, addr: ptr_addr, wdata: '0, be: BE_WORD}; // [RL4] [RL8]
        end else if (ir.op == jump_op) begin
          next_pc    = ea_word; // [RL19]
          next_done  = 1'b1;
          next_state = st_idle;
        end else if (ir.op == jump_and_save) begin
          // interrupt use: pc already holds the return point
          next_req   = '{valid: 1'b1, we: 1'b1, addr: ea_word,
                         wdata: {1'b0, ir.intr ? pc : pc + 15'h0001}, be: BE_WORD}; // [RL20]
          next_state = st_write;
        end else if (ir.op inside {store_acc_word, store_acc_byte, store_index_word, store_index_byte}) begin
          if (byte_eff) begin
            next_req = '{valid: 1'b1, we: 1'b1, addr: ea_word, wdata: {src_byte, src_byte},
                         be: ea_lane ? BE_LOWER : BE_UPPER}; // [RL13] [RL24]
          end else begin
            next_req = '{valid: 1'b1, we: 1'b1, addr: ea_word,
                         wdata: (ir.op == store_acc_word) ? acc : index, be: BE_WORD}; // [RL12]
          end
          next_state = st_write;
        end else if (is_scan) begin
          next_state = st_scan;
        end else begin
          next_req   = '{valid: 1'b1, we: 1'b0, addr: ea_word, wdata: '0, be: BE_WORD};
          next_state = st_read;
        end
      end
      st_ptr: begin
        if (mem_ack) begin
          next_ptr    = mem_rdata;              // all 16 bits, no indirect flag
          next_ptr_ok = 1'b1;
          next_state  = st_decode;
        end
      end
      st_read: begin
        if (mem_ack) begin
          next_state = st_idle;
          next_done  = 1'b1;
          unique case (ir.op)
            load_acc_word, load_acc_byte:     next_acc   = operand; // [RL12] [RL13]
            load_index_word, load_index_byte: next_index = operand; // [RL13]
            xor_acc_byte: begin
              if (byte_eff) begin
                next_acc = {acc[15:8], acc[7:0] ^ rbyte}; // [RL11]
              end else begin
                next_acc = acc ^ mem_rdata;
              end
            end
            compare_skip_word, compare_skip_byte: begin
              if (acc == operand) begin
                next_skip = 2'h2; // [RL15] [RL16]
              end else if ($signed(acc) > $signed(operand)) begin
                next_skip = 2'h1; // [RL15]
              end
            end
            exchange_mem_acc, exchange_mem_acc_byte: begin
              next_done  = 1'b0;
              next_state = st_write;
              next_ptr   = operand; // parked until the write lands
              if (byte_eff) begin
                next_req = '{valid: 1'b1, we: 1'b1, addr: ea_word, wdata: {acc[7:0], acc[7:0]},
                             be: ea_lane ? BE_LOWER : BE_UPPER};             // [RL14] [RL24]
              end else begin
                next_req = '{valid: 1'b1, we: 1'b1, addr: ea_word, wdata: acc, be: BE_WORD};
              end
            end
            increment_skip_zero: begin
              next_done  = 1'b0;
              next_state = st_write;
              next_req   = '{valid: 1'b1, we: 1'b1, addr: ea_word, wdata: incr, be: BE_WORD}; // [RL17]
              // interrupt use at zero: notice later, no skip, flag kept
              if (!ir.intr || incr != '0) begin
                if (incr == '0) begin
                  next_skip = 2'h1; // [RL17]
                end
                if (mem_rdata == 16'h7FFF) begin
                  next_ov = 1'b1; // [RL17]
                end
              end
            end
            default: next_acc = acc;
          endcase
        end
      end
      st_write: begin
        if (mem_ack) begin
          next_state = st_idle;
          next_done  = 1'b1;
          // echo leaves with done, once the zero is written
          next_echo = ir.intr && ir.op == increment_skip_zero && mem_req.wdata == '0; // [RL18]
          if (ir.op inside {exchange_mem_acc, exchange_mem_acc_byte}) begin
            next_acc = ptr; // [RL12] [RL14]
          end
          if (ir.op == jump_and_save) begin
            next_pc     = ea_word + 15'h0001; // [RL20]
            next_intdis = ir.intr;            // [RL20]
          end
        end
      end
      st_scan: begin
        if (mem_req.valid) begin
          if (mem_ack) begin
            next_index = index - 16'h0001;      // x counts down per element
            if (acc == operand) begin
              next_state = st_idle;             // match: no skip
              next_done  = 1'b1; // [RL21] [RL22]
            end
          end
        end else if (index == '0) begin
          next_skip  = 2'h1;                    // exhausted without match
          next_state = st_idle;
          next_done  = 1'b1; // [RL21] [RL22]
        end else if (irq_pending) begin
          // pc stays on the scan so re-execution resumes with the kept x
          next_yield = 1'b1;
          next_state = st_idle; // [RL23]
        end else begin
          next_req = '{valid: 1'b1, we: 1'b0, addr: ea_word, wdata: '0, be: BE_WORD}; // [RL21] [RL22]
        end
      end
      default: next_state = st_idle;
    endcase
    // completion advances pc past the instruction and any skip
    if (next_done && !ir.intr && !(ir.op inside {jump_op, jump_and_save}) && state != st_decode) begin
      next_pc = pc + 15'h0001 + {13'h0000, next_skip}; // [RL15] [RL17]
    end
    // every instruction but the suspend itself uses up one count
    if (next_done && sus_cnt != '0 && ir.op != suspend_byte_for_count) begin
      next_sus_cnt = sus_cnt - 1'b1; // [RL2]
    end
    if (state == st_decode && ir.op == suspend_byte_for_count) begin
      next_sus_cnt = ir.count; // [RL2]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencer and instruction latch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state  <= st_idle;
      ir     <= '0;
      ptr    <= '0;
      ptr_ok <= 1'b0;
      skip   <= 2'h0;
    end else begin
      state  <= next_state;
      ptr    <= next_ptr;
      ptr_ok <= next_ptr_ok;
      skip   <= next_skip;
      if (state == st_idle && instr_valid) begin
        ir <= instr;                            // held until done
      end
    end
  end

  // mode state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      byte_mode <= 1'b0;                        // word mode by default
      sus_cnt   <= '0;
    end else begin
      byte_mode <= next_mode;
      sus_cnt   <= next_sus_cnt;
    end
  end

  // memory request register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mem_req <= '0;
    end else begin
      mem_req <= next_req;
    end
  end

  // programmer-visible registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc               <= A_RESET;
      index             <= X_RESET;
      pc                <= P_RESET;
      arith_excess_flag <= 1'b0;
    end else begin
      acc               <= next_acc;
      index             <= next_index;
      pc                <= next_pc;
      arith_excess_flag <= next_ov;
    end
  end

  // handshake and event pulses
  always_ff @(posedge clk) begin
    if (!nrst) begin
      instr_ready <= 1'b0;
      done        <= 1'b0;
      echo        <= 1'b0;
      int_disable <= 1'b0;
      scan_yield  <= 1'b0;
    end else begin
      instr_ready <= (next_state == st_idle);
      done        <= next_done;
      echo        <= next_echo; // [RL18]
      int_disable <= next_intdis;
      scan_yield  <= next_yield;
    end
  end

endmodule : byte_mode_memref_exec

//--- testbench/memref_props.sv
// port checker for the memory-reference executor
module memref_props
  import memref_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // observed ports
  input wire logic              done,
  input wire logic              echo,
  input wire logic              int_disable,
  input wire logic              scan_yield,
  input wire mem_req_s          mem_req,
  input wire logic              mem_ack,
  input wire logic [WORD_W-1:0] acc,
  input wire logic [WADDR_W-1:0] pc,
  input wire logic              arith_excess_flag,
  input wire logic              byte_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // a request still waiting for its answer
  sequence req_wait;
    mem_req.valid && !mem_ack;
  endsequence
  req_hold_a: assert property (req_wait |=> $stable(mem_req))
    else $error("request moved before ack");
  lane_copy_a: assert property (mem_req.valid && mem_req.we && mem_req.be != BE_WORD |->
    (mem_req.be == BE_UPPER || mem_req.be == BE_LOWER) && mem_req.wdata[15:8] == mem_req.wdata[7:0])
    else $error("bad byte lane write");
  word_write_a: assert property (mem_req.valid && mem_req.we && !byte_mode |-> mem_req.be == BE_WORD)
    else $error("partial write in word mode");
  echo_done_a: assert property (echo |-> done && $stable(arith_excess_flag))
    else $error("echo without done or flag moved");
  int_off_a: assert property (int_disable |-> done)
    else $error("disable pulse without done");
  yield_hold_a: assert property (scan_yield |-> !done && $stable(pc))
    else $error("yield moved pc");
  flag_keep_a: assert property (arith_excess_flag |=> arith_excess_flag)
    else $error("overflow flag dropped");
  acc_move_a: assert property (!$stable(acc) |-> done)
    else $error("acc moved without done");
  pc_move_a: assert property (!$stable(pc) |-> done)
    else $error("pc moved without done");
endmodule : memref_props

bind byte_mode_memref_exec memref_props memref_props_inst (.clk, .nrst, .done, .echo, .int_disable,
  .scan_yield, .mem_req, .mem_ack, .acc, .pc, .arith_excess_flag, .byte_mode);

//--- testbench/mem_model.sv
// main memory model, answers promptly or after three wait states
module mem_model
  import memref_pkg::*;
(
  // clock and control
  input wire logic         clk,
  input wire logic         slow,
  // request and answer
  input wire mem_req_s     mem_req,
  output logic             mem_ack,
  output logic [WORD_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WORD_W-1:0] m [0:255];  // low words only, enough here
  logic [1:0]        lag;        // wait states so far
  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 16'h0000;
    lag       = 2'h0;
  end
  // idle data line flips each cycle so stale data never matches
  always @(posedge clk) begin
    if (mem_req.valid && !mem_ack && (!slow || lag == 2'h3)) begin
      mem_ack   <= 1'b1;
      mem_rdata <= m[mem_req.addr[7:0]];
      if (mem_req.we && mem_req.be[1]) m[mem_req.addr[7:0]][15:8] <= mem_req.wdata[15:8];
      if (mem_req.we && mem_req.be[0]) m[mem_req.addr[7:0]][7:0] <= mem_req.wdata[7:0];
      lag <= 2'h0;
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.valid && !mem_ack) lag <= lag + 2'h1;
    end
  end
endmodule : mem_model

//--- testbench/byte_mode_memref_exec_tb.sv
// self-checking bench for the memory-reference executor
module byte_mode_memref_exec_tb
  import memref_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, instr_valid, irq_pending, slow, instr_ready, done, echo, int_disable, scan_yield;
  logic mem_ack, arith_excess_flag, byte_mode;
  instr_s            instr;
  mem_req_s          mem_req;
  logic [WORD_W-1:0] mem_rdata, acc, index;
  logic [WADDR_W-1:0] pc, p0;
  int n_fail, check_count, cyc;
  op_e wops [3] = '{word_mode_set_op, force_word_op_a, force_word_op_b};
  byte_mode_memref_exec byte_mode_memref_exec_inst (.clk, .nrst, .instr_valid, .instr, .instr_ready, .done,
    .irq_pending, .echo, .int_disable, .scan_yield, .mem_req, .mem_ack, .mem_rdata, .acc, .index, .pc,
    .arith_excess_flag, .byte_mode);
  mem_model mem_model_inst (.clk, .slow, .mem_req, .mem_ack, .mem_rdata);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic poke(input logic [7:0] a, input logic [15:0] v);
    mem_model_inst.m[a] = v;
  endtask : poke
  function automatic logic [15:0] peek(input logic [7:0] a);
    return mem_model_inst.m[a];
  endfunction : peek
  function automatic logic [15:0] dp();
    return 16'(pc - p0);
  endfunction : dp
  // offer one instruction and wait for done or a yield
  task automatic op(input op_e o, input addr_mode_e md, input logic [9:0] d, input logic it = 1'b0);
    p0 = pc;
    while (!instr_ready) @(negedge clk);
    instr_valid = 1'b1;
    instr = '{o, md, 1'b0, d, 8'h01, it};
    @(negedge clk);
    instr_valid = 1'b0;
    while (!(done || scan_yield)) @(negedge clk);
  endtask : op
  task automatic t_bytes();
    poke(8'h20, 16'hABCD); poke(8'h21, 16'h0003); poke(8'h22, 16'h0040); poke(8'h40, 16'h1357);
    op(set_byte_mode_op, am_direct, 10'h000);
    check(16'(byte_mode), 16'h0001);
    op(load_acc_byte, am_direct, 10'h040);
    check(acc, 16'h00AB);
    op(load_index_word, am_direct, 10'h021);
    op(load_acc_byte, am_indexed, 10'h03E);
    check(acc, 16'h00CD);
    op(store_acc_byte, am_indirect, 10'h022);
    check(peek(8'h20), 16'hCDCD);
    op(load_acc_word, am_direct, 10'h010);
    op(xor_acc_byte, am_postidx, 10'h022);
    check(acc, 16'h8237);
    op(exchange_mem_acc_byte, am_direct, 10'h041);
    check(acc, 16'h00CD);
    check(peek(8'h20), 16'hCD37);
    op(compare_skip_byte, am_direct, 10'h040);
    check(dp(), 16'h0003);
    for (int i = 0; i < 3; i++) begin
      poke(8'h30, 16'h00CC + 16'(i));
      op(compare_skip_word, am_direct, 10'h030);
      check(dp(), 16'(i == 2 ? 1 : 2 + i));
    end
    op(suspend_byte_for_count, am_direct, 10'h000);
    op(load_acc_byte, am_direct, 10'h040);
    check(acc, 16'h1357);
    op(load_acc_byte, am_direct, 10'h040);
    check(acc, 16'h00CD);
  endtask : t_bytes
  task automatic t_flow();
    poke(8'h50, 16'hFFFF); poke(8'h51, 16'h7FFF); poke(8'h52, 16'hFFFF);
    op(increment_skip_zero, am_direct, 10'h050);
    check(peek(8'h50), 16'h0000);
    check(dp(), 16'h0002);
    op(increment_skip_zero, am_direct, 10'h051);
    check(16'(arith_excess_flag), 16'h0001);
    op(increment_skip_zero, am_direct, 10'h052, 1'b1);
    check({echo, dp()}, 17'h10000);
    op(jump_op, am_direct, 10'h060);
    check(16'(pc), 16'h0060);
    op(jump_and_save, am_direct, 10'h070);
    check(peek(8'h70), 16'h0061);
    check(16'(pc), 16'h0071);
    op(jump_and_save, am_direct, 10'h074, 1'b1);
    check(16'(int_disable), 16'h0001);
    for (int i = 0; i < 3; i++) begin
      op(set_byte_mode_op, am_direct, 10'h000);
      op(wops[i], am_direct, 10'h000);
      check(16'(byte_mode), 16'h0000);
    end
  endtask : t_flow
  task automatic t_scan();
    poke(8'h05, 16'h007F); poke(8'h06, 16'h0004); poke(8'h07, 16'h0009); poke(8'h08, 16'h0003);
    for (int i = 0; i < 4; i++) poke(8'h80 + 8'(i), 16'(i + 1));
    op(load_index_word, am_direct, 10'h006);
    op(load_acc_word, am_direct, 10'h007);
    op(scan_words, am_postidx, 10'h005);
    check({index, dp()}, 32'h00000002);
    op(load_index_word, am_direct, 10'h006);
    op(load_acc_word, am_direct, 10'h008);
    slow = 1'b1;
    irq_pending = 1'b1;
    op(scan_words, am_postidx, 10'h005);
    check({16'(scan_yield), index, dp()}, 48'h000100040000);
    irq_pending = 1'b0;
    op(scan_words, am_postidx, 10'h005);
    check(dp(), 16'h0001);
  endtask : t_scan
  initial begin
    nrst = 1'b0; instr_valid = 1'b0; irq_pending = 1'b0; slow = 1'b0; instr = '0;
    poke(8'h10, 16'h8234); poke(8'h11, 16'h0055);
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    op(load_acc_word, am_direct, 10'h010);
    check({acc, dp()}, 32'h82340001);
    op(exchange_mem_acc, am_direct, 10'h011);
    check({acc, peek(8'h11)}, 32'h00558234);
    op(store_acc_word, am_direct, 10'h012);
    check(peek(8'h12), 16'h0055);
    t_bytes();
    t_flow();
    t_scan();
    end_sim();
  end
endmodule : byte_mode_memref_exec_tb
